/* File: rtl/arsf_pkg.sv */
// Package of constants for the converter result and status flag block
package arsf_pkg;
  localparam int NCH         = 8;
  localparam int CH_W        = 3;
  localparam int DATA_W      = 10;
  localparam int ADDR_W      = 8;
  localparam int IRQ_W       = 3;
  // Register byte offsets
  localparam logic [7:0] OFF_CTRL     = 8'h00;
  localparam logic [7:0] OFF_MODE     = 8'h04;
  localparam logic [7:0] OFF_CH_ENA   = 8'h10;
  localparam logic [7:0] OFF_CH_DIS   = 8'h14;
  localparam logic [7:0] OFF_CH_STAT  = 8'h18;
  localparam logic [7:0] OFF_STATUS   = 8'h1C;
  localparam logic [7:0] OFF_LAST     = 8'h20;
  localparam logic [7:0] OFF_IRQ_STAT = 8'h28;
  localparam logic [7:0] OFF_IRQ_MASK = 8'h2C;
  localparam logic [7:0] OFF_RES_BASE = 8'h40;
  // Field positions
  localparam int CTRL_START_BIT  = 0;
  localparam int MODE_SLEEP_BIT  = 0;
  localparam int ST_DONE_LSB     = 0;
  localparam int ST_OVR_LSB      = 8;
  localparam int ST_DATA_READY_FLAG_BIT     = 16;
  localparam int ST_GOVR_BIT     = 17;
  localparam int LAST_CH_LSB     = 12;
  localparam int IRQ_EOC_BIT     = 0;
  localparam int IRQ_GOVR_BIT    = 1;
  localparam int IRQ_OVR_BIT     = 2;
  // Reset values
  localparam logic [NCH-1:0]    RST_CH_ENA = 8'h00;
  localparam logic [DATA_W-1:0] RST_DATA   = 10'h000;
  localparam logic [IRQ_W-1:0]  RST_IRQ    = 3'h0;
endpackage

/* File: rtl/arsf_apb_if.sv */
// APB slave handshake: access strobe, ready and registered read data
`timescale 1ns/1ps
module arsf_apb_if (
  input  wire logic        clk,
  input  wire logic        rst_n,
  input  wire logic        psel,
  input  wire logic        penable,
  input  wire logic [31:0] rdata,
  input  wire logic        err,
  output logic             fire,
  output logic             pready_reg,
  output logic [31:0]      prdata_reg,
  output logic             pslverr_reg
);
  // First access cycle carries all effects; ready follows one cycle later
  assign fire = psel & penable & ~pready_reg;

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      pready_reg <= 1'b0;
    end else begin
      pready_reg <= fire;
    end
  end

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      prdata_reg  <= 32'h0000_0000;
      pslverr_reg <= 1'b0;
    end else if (fire) begin
      prdata_reg  <= rdata;
      pslverr_reg <= err;
    end else if (pready_reg) begin
      prdata_reg  <= 32'h0000_0000;
      pslverr_reg <= 1'b0;
    end
  end
endmodule

/* File: rtl/arsf_irq.sv */
// Sticky event status, mask and level interrupt output
`timescale 1ns/1ps
module arsf_irq #(
  parameter int W = 3
) (
  input  wire logic         clk,
  input  wire logic         rst_n,
  input  wire logic [W-1:0] event_set,
  input  wire logic         clr_wr,
  input  wire logic         mask_wr,
  input  wire logic [W-1:0] wdata,
  output logic [W-1:0]      status_reg,
  output logic [W-1:0]      mask_reg,
  output logic              irq_reg
);
  logic [W-1:0] status_next;

  // Set wins over a write-one clear in the same cycle
  always_comb begin
    status_next = (status_reg & ~(clr_wr ? wdata : '0)) | event_set;
  end

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      status_reg <= '0;
    end else begin
      status_reg <= status_next;
    end
  end

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      mask_reg <= '0;
    end else if (mask_wr) begin
      mask_reg <= wdata;
    end
  end

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      irq_reg <= 1'b0;
    end else begin
      irq_reg <= |(status_next & mask_reg);
    end
  end
endmodule

/* File: rtl/arsf_top.sv */
// Converter result registers with done, data-ready and overrun flags
`timescale 1ns/1ps
module arsf_top #(
  parameter int NCH    = arsf_pkg::NCH,
  parameter int CH_W   = arsf_pkg::CH_W,
  parameter int DATA_W = arsf_pkg::DATA_W
) (
  input  wire logic                         SYS_CLK,
  input  wire logic                         RESET_N,
  input  wire logic                         PSEL,
  input  wire logic                         PENABLE,
  input  wire logic                         PWRITE,
  input  wire logic [arsf_pkg::ADDR_W-1:0]  PADDR,
  input  wire logic [31:0]                  PWDATA,
  output logic      [31:0]                  PRDATA,
  output logic                              PREADY,
  output logic                              PSLVERR,
  input  wire logic                         EOC_VALID,
  input  wire logic [CH_W-1:0]              EOC_CHANNEL,
  input  wire logic [DATA_W-1:0]            EOC_DATA,
  output logic      [NCH-1:0]               CH_ENABLE,
  output logic                              START_CONV,
  output logic                              SLEEP_MODE,
  output logic                              IRQ
);
  // One-hot decode of a channel number
  function automatic logic [NCH-1:0] ch_onehot(input logic [CH_W-1:0] ch);
    logic [NCH-1:0] v;
    v = '0;
    v[ch] = 1'b1;
    return v;
  endfunction

  // Address of a channel result register
  function automatic logic [7:0] res_addr(input int idx);
    return arsf_pkg::OFF_RES_BASE + 8'(idx * 4);
  endfunction

  logic                        fire;
  logic                        pready_int;
  logic [31:0]                 prdata_int;
  logic                        pslverr_int;
  logic                        wr_fire;
  logic                        rd_fire;
  logic [31:0]                 rdata;
  logic                        addr_err;

  logic [NCH-1:0]              ch_en_reg;
  logic [NCH-1:0]              ch_en_next;
  logic [NCH-1:0]              done_reg;
  logic [NCH-1:0]              done_next;
  logic [NCH-1:0]              ovr_reg;
  logic [NCH-1:0]              ovr_next;
  logic                        data_ready_flag_reg;
  logic                        data_ready_flag_next;
  logic                        govr_reg;
  logic                        govr_next;
  logic [DATA_W-1:0]           res_reg [NCH];
  logic [DATA_W-1:0]           last_data_reg;
  logic [CH_W-1:0]             last_ch_reg;
  logic                        start_reg;
  logic                        sleep_reg;

  logic [NCH-1:0]              dis_now;
  logic [NCH-1:0]              eoc_hot;
  logic [NCH-1:0]              set_done;
  logic [NCH-1:0]              clr_done;
  logic [NCH-1:0]              rd_res;
  logic                        eoc_store;
  logic                        rd_last;
  logic                        rd_status;
  logic                        new_govr;
  logic [NCH-1:0]              new_ovr;
  logic [arsf_pkg::IRQ_W-1:0]  irq_events;
  logic [arsf_pkg::IRQ_W-1:0]  irq_status;
  logic [arsf_pkg::IRQ_W-1:0]  irq_mask;
  logic                        irq_int;
  logic                        irq_clr_wr;
  logic                        irq_mask_wr;
  logic                        ctrl_wr;
  logic                        mode_wr;
  logic                        ena_wr;
  logic                        dis_wr;

  arsf_apb_if u_apb (
    .clk         (SYS_CLK),
    .rst_n       (RESET_N),
    .psel        (PSEL),
    .penable     (PENABLE),
    .rdata       (rdata),
    .err         (addr_err),
    .fire        (fire),
    .pready_reg  (pready_int),
    .prdata_reg  (prdata_int),
    .pslverr_reg (pslverr_int)
  );

  assign PREADY  = pready_int;
  assign PRDATA  = prdata_int;
  assign PSLVERR = pslverr_int;

  assign wr_fire = fire & PWRITE;
  assign rd_fire = fire & ~PWRITE;

  // Register read strobes, taken in the same cycle as the data is captured
  assign rd_last   = rd_fire & (PADDR == arsf_pkg::OFF_LAST);
  assign rd_status = rd_fire & (PADDR == arsf_pkg::OFF_STATUS);

  // Register write strobes
  assign ctrl_wr = wr_fire & (PADDR == arsf_pkg::OFF_CTRL);
  assign mode_wr = wr_fire & (PADDR == arsf_pkg::OFF_MODE);
  assign ena_wr  = wr_fire & (PADDR == arsf_pkg::OFF_CH_ENA);
  assign dis_wr  = wr_fire & (PADDR == arsf_pkg::OFF_CH_DIS);

  always_comb begin
    rd_res = '0;
    for (int i = 0; i < NCH; i++) begin
      rd_res[i] = rd_fire & (PADDR == res_addr(i));
    end
  end

  // Channel disable written this cycle
  assign dis_now = dis_wr ? PWDATA[NCH-1:0] : '0;

  // Result is stored only for a channel that stays enabled
  assign eoc_hot   = ch_onehot(EOC_CHANNEL);
  assign eoc_store = EOC_VALID & |(eoc_hot & ch_en_reg & ~dis_now);
  assign set_done  = eoc_store ? eoc_hot : '0;

  // Clear of done flags: the addressed result channel, or the last stored channel on a last read
  assign clr_done = rd_res | (rd_last ? ch_onehot(last_ch_reg) : '0);

  always_comb begin
    done_next = (done_reg & ~clr_done) | set_done;
  end

  // Channel overrun: completes while its done flag still stands
  assign new_ovr = set_done & done_reg & ~clr_done;

  always_comb begin
    ovr_next = (ovr_reg & ~(rd_status ? '1 : '0)) | new_ovr;
  end

  // Data-ready: only a stored result sets it, only the last read clears it
  always_comb begin
    data_ready_flag_next = (data_ready_flag_reg & ~rd_last) | eoc_store;
  end

  // General overrun: unread last result is being overwritten
  assign new_govr = eoc_store & data_ready_flag_reg & ~rd_last;

  always_comb begin
    govr_next = (govr_reg & ~rd_status) | new_govr;
  end

  always_comb begin
    ch_en_next = ch_en_reg;
    if (ena_wr) begin
      ch_en_next = ch_en_reg | PWDATA[NCH-1:0];
    end
    ch_en_next = ch_en_next & ~dis_now;
  end

  always_ff @(posedge SYS_CLK or negedge RESET_N) begin
    if (!RESET_N) begin
      ch_en_reg <= arsf_pkg::RST_CH_ENA;
    end else begin
      ch_en_reg <= ch_en_next;
    end
  end

  always_ff @(posedge SYS_CLK or negedge RESET_N) begin
    if (!RESET_N) begin
      done_reg <= '0;
    end else begin
      done_reg <= done_next;
    end
  end

  // Channel overrun flags
  always_ff @(posedge SYS_CLK or negedge RESET_N) begin
    if (!RESET_N) begin
      ovr_reg <= '0;
    end else begin
      ovr_reg <= ovr_next;
    end
  end

  always_ff @(posedge SYS_CLK or negedge RESET_N) begin
    if (!RESET_N) begin
      data_ready_flag_reg <= 1'b0;
    end else begin
      data_ready_flag_reg <= data_ready_flag_next;
    end
  end

  // General overrun flag
  always_ff @(posedge SYS_CLK or negedge RESET_N) begin
    if (!RESET_N) begin
      govr_reg <= 1'b0;
    end else begin
      govr_reg <= govr_next;
    end
  end

  // Result storage for each channel and for the last conversion
  always_ff @(posedge SYS_CLK or negedge RESET_N) begin
    if (!RESET_N) begin
      for (int i = 0; i < NCH; i++) begin
        res_reg[i] <= arsf_pkg::RST_DATA;
      end
    end else if (eoc_store) begin
      res_reg[EOC_CHANNEL] <= EOC_DATA;
    end
  end

  always_ff @(posedge SYS_CLK or negedge RESET_N) begin
    if (!RESET_N) begin
      last_data_reg <= arsf_pkg::RST_DATA;
    end else if (eoc_store) begin
      last_data_reg <= EOC_DATA;
    end
  end

  always_ff @(posedge SYS_CLK or negedge RESET_N) begin
    if (!RESET_N) begin
      last_ch_reg <= '0;
    end else if (eoc_store) begin
      last_ch_reg <= EOC_CHANNEL;
    end
  end

  // Start pulse and sleep mode setting
  always_ff @(posedge SYS_CLK or negedge RESET_N) begin
    if (!RESET_N) begin
      start_reg <= 1'b0;
    end else begin
      start_reg <= ctrl_wr & PWDATA[arsf_pkg::CTRL_START_BIT];
    end
  end

  always_ff @(posedge SYS_CLK or negedge RESET_N) begin
    if (!RESET_N) begin
      sleep_reg <= 1'b0;
    end else if (mode_wr) begin
      sleep_reg <= PWDATA[arsf_pkg::MODE_SLEEP_BIT];
    end
  end

  assign CH_ENABLE  = ch_en_reg;
  assign START_CONV = start_reg;
  assign SLEEP_MODE = sleep_reg;

  // Interrupt events
  always_comb begin
    irq_events = '0;
    irq_events[arsf_pkg::IRQ_EOC_BIT]  = eoc_store;
    irq_events[arsf_pkg::IRQ_GOVR_BIT] = new_govr;
    irq_events[arsf_pkg::IRQ_OVR_BIT]  = |new_ovr;
  end

  assign irq_clr_wr  = wr_fire & (PADDR == arsf_pkg::OFF_IRQ_STAT);
  assign irq_mask_wr = wr_fire & (PADDR == arsf_pkg::OFF_IRQ_MASK);

  arsf_irq #(
    .W (arsf_pkg::IRQ_W)
  ) u_irq (
    .clk        (SYS_CLK),
    .rst_n      (RESET_N),
    .event_set  (irq_events),
    .clr_wr     (irq_clr_wr),
    .mask_wr    (irq_mask_wr),
    .wdata      (PWDATA[arsf_pkg::IRQ_W-1:0]),
    .status_reg (irq_status),
    .mask_reg   (irq_mask),
    .irq_reg    (irq_int)
  );

  assign IRQ = irq_int;

  // Read data multiplexer and unmapped address detection
  always_comb begin
    rdata    = 32'h0000_0000;
    addr_err = 1'b0;
    unique case (PADDR)
      arsf_pkg::OFF_CTRL: begin
        rdata = 32'h0000_0000;
      end
      arsf_pkg::OFF_MODE: begin
        rdata[arsf_pkg::MODE_SLEEP_BIT] = sleep_reg;
      end
      arsf_pkg::OFF_CH_ENA, arsf_pkg::OFF_CH_DIS: begin
        rdata = 32'h0000_0000;
      end
      arsf_pkg::OFF_CH_STAT: begin
        rdata[NCH-1:0] = ch_en_reg;
      end
      arsf_pkg::OFF_STATUS: begin
        rdata[arsf_pkg::ST_DONE_LSB +: NCH] = done_reg;
        rdata[arsf_pkg::ST_OVR_LSB +: NCH]  = ovr_reg;
        rdata[arsf_pkg::ST_DATA_READY_FLAG_BIT]        = data_ready_flag_reg;
        rdata[arsf_pkg::ST_GOVR_BIT]        = govr_reg;
      end
      arsf_pkg::OFF_LAST: begin
        rdata[DATA_W-1:0]                      = last_data_reg;
        rdata[arsf_pkg::LAST_CH_LSB +: CH_W]   = last_ch_reg;
      end
      arsf_pkg::OFF_IRQ_STAT: begin
        rdata[arsf_pkg::IRQ_W-1:0] = irq_status;
      end
      arsf_pkg::OFF_IRQ_MASK: begin
        rdata[arsf_pkg::IRQ_W-1:0] = irq_mask;
      end
      default: begin
        addr_err = 1'b1;
        for (int i = 0; i < NCH; i++) begin
          if (PADDR == res_addr(i)) begin
            rdata[DATA_W-1:0] = res_reg[i];
            addr_err          = 1'b0;
          end
        end
      end
    endcase
  end
endmodule

/* File: bench/arsf_top_props.sv */
// Port-level assertions for the converter flag block
`timescale 1ns/1ps
module arsf_top_props #(
  parameter int NCH    = arsf_pkg::NCH,
  parameter int CH_W   = arsf_pkg::CH_W,
  parameter int DATA_W = arsf_pkg::DATA_W
) (
  input wire logic              SYS_CLK,
  input wire logic              RESET_N,
  input wire logic              PSEL,
  input wire logic              PENABLE,
  input wire logic              PWRITE,
  input wire logic [7:0]        PADDR,
  input wire logic [31:0]       PWDATA,
  input wire logic [31:0]       PRDATA,
  input wire logic              PREADY,
  input wire logic              PSLVERR,
  input wire logic              EOC_VALID,
  input wire logic [CH_W-1:0]   EOC_CHANNEL,
  input wire logic [DATA_W-1:0] EOC_DATA,
  input wire logic [NCH-1:0]    CH_ENABLE,
  input wire logic              START_CONV,
  input wire logic              SLEEP_MODE,
  input wire logic              IRQ
);
  logic tk;
  logic tw;
  assign tk = PSEL && PENABLE && !PREADY;
  assign tw = tk && PWRITE;
  default clocking cb @(posedge SYS_CLK); endclocking
  default disable iff (!RESET_N);
  property p_ready; tk |=> PREADY; endproperty
  a_ready: assert property (p_ready) else $error("ready missing");
  property p_pulse; PREADY |=> !PREADY; endproperty
  a_pulse: assert property (p_pulse) else $error("ready too long");
  property p_idle; !PREADY |-> PRDATA == 32'h0 && !PSLVERR; endproperty
  a_idle: assert property (p_idle) else $error("answer outside access");
  property p_unmap; tk && PADDR == 8'h30 |=> PSLVERR; endproperty
  a_unmap: assert property (p_unmap) else $error("no error on hole");
  property p_start; tw && PADDR == arsf_pkg::OFF_CTRL && PWDATA[0]
    |=> START_CONV ##1 !START_CONV; endproperty
  a_start: assert property (p_start) else $error("start pulse bad");
  property p_sleep; tw && PADDR == arsf_pkg::OFF_MODE
    |=> SLEEP_MODE == $past(PWDATA[0]); endproperty
  a_sleep: assert property (p_sleep) else $error("sleep bad");
  property p_ena; tw && PADDR == arsf_pkg::OFF_CH_ENA
    |=> CH_ENABLE == ($past(CH_ENABLE) | $past(PWDATA[NCH-1:0])); endproperty
  a_ena: assert property (p_ena) else $error("enable bad");
  property p_dis; tw && PADDR == arsf_pkg::OFF_CH_DIS
    |=> CH_ENABLE == ($past(CH_ENABLE) & ~$past(PWDATA[NCH-1:0]));
  endproperty
  a_dis: assert property (p_dis) else $error("disable bad");
  property p_hold; !tw |=> $stable(CH_ENABLE); endproperty
  a_hold: assert property (p_hold) else $error("mask moved");
endmodule

bind arsf_top arsf_top_props #(.NCH(NCH), .CH_W(CH_W), .DATA_W(DATA_W))
u_props (
  .SYS_CLK(SYS_CLK), .RESET_N(RESET_N), .PSEL(PSEL), .PENABLE(PENABLE),
  .PWRITE(PWRITE), .PADDR(PADDR), .PWDATA(PWDATA), .PRDATA(PRDATA),
  .PREADY(PREADY), .PSLVERR(PSLVERR), .EOC_VALID(EOC_VALID),
  .EOC_CHANNEL(EOC_CHANNEL), .EOC_DATA(EOC_DATA), .CH_ENABLE(CH_ENABLE),
  .START_CONV(START_CONV), .SLEEP_MODE(SLEEP_MODE), .IRQ(IRQ)
);

/* File: bench/arsf_core_model.sv */
// Behavioural conversion core giving end-of-conversion pulses
`timescale 1ns/1ps
module arsf_core_model (
  input  wire logic        clk,
  input  wire logic        start_conv,
  output logic             eoc_valid,
  output logic [2:0]       eoc_channel,
  output logic [9:0]       eoc_data
);
  int starts = 0;
  initial begin
    eoc_valid = 1'h0;
    eoc_channel = 3'h5;
    eoc_data = 10'h2A5;
  end
  always @(posedge clk) begin
    if (start_conv) begin
      starts <= starts + 1;
    end
  end
  // One-cycle result, then lines scrambled
  task automatic pulse(input logic [2:0] ch, input logic [9:0] d);
    eoc_valid <= 1'h1;
    eoc_channel <= ch;
    eoc_data <= d;
    @(posedge clk);
    eoc_valid <= 1'h0;
    eoc_channel <= ~ch;
    eoc_data <= ~d;
  endtask
endmodule

/* File: bench/arsf_top_tb.sv */
// Self-checking bench for the converter flag block
`timescale 1ns/1ps
module arsf_top_tb;
  localparam logic [7:0] ST  = arsf_pkg::OFF_STATUS;
  localparam logic [7:0] LST = arsf_pkg::OFF_LAST;
  localparam logic [7:0] IS  = arsf_pkg::OFF_IRQ_STAT;
  logic        SYS_CLK = 1'h0;
  logic        RESET_N;
  logic        PSEL;
  logic        PENABLE;
  logic        PWRITE;
  logic [7:0]  PADDR;
  logic [31:0] PWDATA;
  logic [31:0] PRDATA;
  logic        PREADY;
  logic        PSLVERR;
  logic        EOC_VALID;
  logic [2:0]  EOC_CHANNEL;
  logic [9:0]  EOC_DATA;
  logic [7:0]  CH_ENABLE;
  logic        START_CONV;
  logic        SLEEP_MODE;
  logic        IRQ;
  logic [31:0] rdata;
  logic        serr;
  int          fail_count = 0;
  int          compares = 0;

  always #12.5 SYS_CLK = ~SYS_CLK;

  arsf_top DUT (
    .SYS_CLK(SYS_CLK), .RESET_N(RESET_N), .PSEL(PSEL), .PENABLE(PENABLE),
    .PWRITE(PWRITE), .PADDR(PADDR), .PWDATA(PWDATA), .PRDATA(PRDATA),
    .PREADY(PREADY), .PSLVERR(PSLVERR), .EOC_VALID(EOC_VALID),
    .EOC_CHANNEL(EOC_CHANNEL), .EOC_DATA(EOC_DATA), .CH_ENABLE(CH_ENABLE),
    .START_CONV(START_CONV), .SLEEP_MODE(SLEEP_MODE), .IRQ(IRQ));
  arsf_core_model core (
    .clk(SYS_CLK), .start_conv(START_CONV), .eoc_valid(EOC_VALID),
    .eoc_channel(EOC_CHANNEL), .eoc_data(EOC_DATA));

  task automatic chk(input string n, input logic [31:0] e,
                     input logic [31:0] g);
    compares++;
    if (g !== e) begin
      fail_count++;
      $display("[FAIL] %s expected %h seen %h", n, e, g);
    end
  endtask

  // One APB transfer, optionally with a result landing at its take edge
  task automatic xfer(input logic w, input logic [7:0] a,
                      input logic [31:0] wd, input logic e,
                      input logic [2:0] ch, input logic [9:0] d);
    int n;
    PSEL <= 1'h1;
    PWRITE <= w;
    PADDR <= a;
    PWDATA <= wd;
    @(posedge SYS_CLK);
    PENABLE <= 1'h1;
    if (e) fork core.pulse(ch, d); join_none
    n = 0;
    do begin
      @(posedge SYS_CLK);
      n++;
    end while (PREADY !== 1'h1 && n < 20);
    if (n >= 20) fail_count++;
    rdata = PRDATA;
    serr = PSLVERR;
    PSEL <= 1'h0;
    PENABLE <= 1'h0;
    @(posedge SYS_CLK);
  endtask

  task automatic wr(input logic [7:0] a, input logic [31:0] v);
    xfer(1'h1, a, v, 1'h0, 3'h0, 10'h0);
  endtask
  task automatic rd(input logic [7:0] a, input logic [31:0] e);
    xfer(1'h0, a, 32'h0, 1'h0, 3'h0, 10'h0);
    chk($sformatf("reg %h", a), e, rdata);
  endtask
  task automatic conv(input logic [2:0] ch, input logic [9:0] d);
    core.pulse(ch, d);
    @(posedge SYS_CLK);
  endtask
  function automatic logic [7:0] ra(input int i);
    return arsf_pkg::OFF_RES_BASE + 8'(4 * i);
  endfunction
  function automatic logic [31:0] st(input logic [7:0] dn,
    input logic [7:0] ov, input logic dr, input logic gv);
    return {14'h0, gv, dr, ov, dn};
  endfunction
  function automatic logic [31:0] lr(input logic [2:0] c, input logic [9:0] d);
    return {17'h0, c, 2'h0, d};
  endfunction

  task automatic t_regs;
    rd(ST, 32'h0);
    wr(arsf_pkg::OFF_MODE, 32'h1);
    wr(arsf_pkg::OFF_CTRL, 32'h1);
    rd(arsf_pkg::OFF_MODE, 32'h1);
    chk("sleep", 32'h1, 32'(SLEEP_MODE));
    chk("starts", 32'h1, 32'(core.starts));
    xfer(1'h0, 8'h30, 32'h0, 1'h0, 3'h0, 10'h0);
    chk("slverr", 32'(serr), 32'h1);
    chk("hole data", 32'h0, rdata);
    wr(arsf_pkg::OFF_CH_ENA, 32'h0F);
    rd(arsf_pkg::OFF_CH_STAT, 32'h0F);
    rd(arsf_pkg::OFF_CH_DIS, 32'h0);
  endtask
  task automatic t_data_ready_flag;
    conv(3'h1, 10'h155);
    rd(ra(1), 32'h155);
    rd(ST, st(8'h0, 8'h0, 1'h1, 1'h0));
    rd(LST, lr(3'h1, 10'h155));
    rd(ST, 32'h0);
  endtask
  task automatic t_govr;
    conv(3'h0, 10'h0AA);
    conv(3'h2, 10'h2CC);
    rd(ST, st(8'h05, 8'h0, 1'h1, 1'h1));
    xfer(1'h0, ra(3), 32'h0, 1'h1, 3'h0, 10'h111);
    rd(ST, st(8'h05, 8'h01, 1'h1, 1'h1));
  endtask
  task automatic t_ovr;
    conv(3'h0, 10'h222);
    rd(ra(0), 32'h222);
    xfer(1'h0, ST, 32'h0, 1'h1, 3'h0, 10'h333);
    rd(ST, st(8'h05, 8'h0, 1'h1, 1'h1));
    conv(3'h1, 10'h044);
    rd(LST, lr(3'h1, 10'h044));
    xfer(1'h0, ST, 32'h0, 1'h1, 3'h3, 10'h0F0);
    rd(ST, st(8'h0D, 8'h0, 1'h1, 1'h0));
  endtask
  task automatic t_dis;
    xfer(1'h0, LST, 32'h0, 1'h1, 3'h5, 10'h155);
    rd(ST, st(8'h05, 8'h0, 1'h0, 1'h0));
    conv(3'h3, 10'h001);
    xfer(1'h1, arsf_pkg::OFF_CH_DIS, 32'h02, 1'h1, 3'h2, 10'h2AA);
    rd(ST, st(8'h0D, 8'h04, 1'h1, 1'h1));
    rd(LST, lr(3'h2, 10'h2AA));
    rd(ra(2), 32'h2AA);
    rd(ra(0), 32'h333);
    xfer(1'h1, arsf_pkg::OFF_CH_DIS, 32'h01, 1'h1, 3'h0, 10'h3FF);
    rd(ST, st(8'h08, 8'h0, 1'h0, 1'h0));
    rd(ra(0), 32'h333);
    chk("enabled", 32'h0C, 32'(CH_ENABLE));
  endtask
  task automatic t_irq;
    wr(IS, 32'h7);
    rd(IS, 32'h0);
    conv(3'h3, 10'h0C3);
    rd(IS, 32'h5);
    chk("irq off", 32'h0, 32'(IRQ));
    wr(arsf_pkg::OFF_IRQ_MASK, 32'h1);
    chk("irq on", 32'h1, 32'(IRQ));
    wr(IS, 32'h1);
    chk("irq clr", 32'h0, 32'(IRQ));
    rd(IS, 32'h4);
    conv(3'h2, 10'h0D2);
    rd(IS, 32'h7);
  endtask
  task automatic t_rst;
    RESET_N <= 1'h0;
    @(posedge SYS_CLK);
    RESET_N <= 1'h1;
    @(posedge SYS_CLK);
    chk("reset outputs", 32'h0, {19'h0, PREADY, PSLVERR, CH_ENABLE,
                                  START_CONV, SLEEP_MODE, IRQ});
    chk("reset rdata", 32'h0, PRDATA);
    rd(ST, 32'h0);
    rd(arsf_pkg::OFF_CH_STAT, 32'h0);
  endtask

  task automatic conclude;
    $display("compares %0d fail_count %0d", compares, fail_count);
    if (fail_count == 0 && compares > 0) $display("All tests passed");
    else $display("Some tests failed");
    $finish;
  endtask

  initial begin
    PSEL = 1'h0;
    PENABLE = 1'h0;
    PWRITE = 1'h0;
    PADDR = 8'h0;
    PWDATA = 32'h0;
    RESET_N = 1'h0;
    repeat (2) @(posedge SYS_CLK);
    RESET_N <= 1'h1;
    @(posedge SYS_CLK);
    t_regs;
    t_data_ready_flag;
    t_govr;
    t_ovr;
    t_dis;
    t_irq;
    t_rst;
    conclude();
  end
  initial begin
    #50000;
    fail_count++;
    conclude();
  end
endmodule
